// *** tcut_timer.sv ***
// Three channel up-count timer with input capture channels
//
// Summary of operation
// - Sixteen bit counter, counts up only
// - Three independent capture channels provided
// - Source zero selects internal kernel clock
// - Enabled prescaler divides input into ticks
// - Sources 5..7 use channel pin edges
// - Sources 1..4 use trigger rising edges
// - Prescaler divides by value plus one
// - New prescaler applied at next update
// - Count zero to reload, then restart
// - Update after N+1 overflows
// - Software trigger clears counter, reloads, updates
// - Update inhibit suppresses update events
// - Update loads repetition, reload, prescaler
// - Eight or thirty-two bit repetition, readable
// - Repetition counter decrements each overflow
// - Independent mode: channels capture independently
// - Capture copies counter, sets flag, interrupt
// - Synchronise, filter pin inputs (trigger sources skip the filter), then detect chosen edge
// - Source select picks own, neighbour, trigger
// - Input prescaler merges edges into one
// - Input channels ignore capture value writes
// - Capture over set flag sets overcapture
`timescale 1ns/100ps
module tcut_timer
	import tcut_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [4:0] clock_source_select,
	input wire logic counter_enable_bit,
	input wire logic [15:0] prescaler_value,
	input wire logic [15:0] auto_reload_value,
	input wire logic [31:0] repetition_count,
	input wire logic repetition_counter_select,
	input wire logic software_update_trigger,
	input wire logic update_inhibit,
	input wire logic count_direction,
	input wire logic [1:0] multi_channel_mode_select,
	input wire logic [3:0] internal_trigger_inputs,
	input wire logic [2:0] channel_input_pin,
	input wire tcut_chcfg_t [2:0] channel_cfg,
	input wire logic [2:0] flag_clear,
	input wire logic [2:0] cv_write,
	input wire logic [15:0] cv_wdata,
	output logic [15:0] counter_value,
	output logic [31:0] repetition_remaining,
	output logic update_event,
	output logic [2:0][15:0] capture_value_register,
	output tcut_chsts_t [2:0] channel_status,
	output logic [2:0] channel_irq,
	output logic [2:0] channel_dma_req
);

	// ****************************************************************
	// Input synchronisers (three stages, change on stage 2/3 agreement)
	// ****************************************************************
	logic [6:0] s1_reg;      // First stage, read only by second
	logic [6:0] s2_reg;      // Second stage
	logic [6:0] s3_reg;      // Third stage
	logic [6:0] sync_reg;    // Accepted level
	logic [6:0] sync_prev_reg;  // Previous accepted level for edge detection
	logic [6:0] raw_in;      // Pins then triggers
	assign raw_in = {internal_trigger_inputs, channel_input_pin};

	// Synchroniser chain to the kernel clock
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end else begin
			s1_reg <= raw_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// Accept a change only once stages two and three agree; keep last level for edges
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sync_reg <= '0;
			sync_prev_reg <= '0;
		end else begin
			sync_prev_reg <= sync_reg;
			for (int i = 0; i < 7; i++) begin
				if (s2_reg[i] == s3_reg[i]) begin
					sync_reg[i] <= s3_reg[i];
				end
			end
		end
	end

	// ****************************************************************
	// Prescaler input clock selection
	// ****************************************************************
	logic [3:0] trg_rise;   // Trigger rising edges
	logic [2:0] pin_rise;   // Pin rising edges
	logic [2:0] pin_fall;   // Pin falling edges
	logic psc_in;           // One pulse per prescaler input clock
	assign trg_rise = sync_reg[6:3] & ~sync_prev_reg[6:3];
	assign pin_rise = sync_reg[2:0] & ~sync_prev_reg[2:0];
	assign pin_fall = ~sync_reg[2:0] & sync_prev_reg[2:0];

	// Source mux; pin mode 5 counts both edges of channel 0
	always_comb begin
		psc_in = 1'b0;
		if (clock_source_select == TCUT_SRC_INT) begin
			psc_in = 1'b1;
		end else if (clock_source_select >= TCUT_SRC_TRG_LO &&
			clock_source_select <= TCUT_SRC_TRG_HI) begin
			psc_in = trg_rise[2'(clock_source_select - TCUT_SRC_TRG_LO)];
		end else if (clock_source_select == TCUT_SRC_CH0_BOTH) begin
			psc_in = pin_rise[0] | pin_fall[0];
		end else if (clock_source_select == TCUT_SRC_CH0_RISE) begin
			psc_in = pin_rise[0];
		end else if (clock_source_select == TCUT_SRC_CH1_RISE) begin
			psc_in = pin_rise[1];
		end
	end

	// ****************************************************************
	// Prescaler, shadowed registers and counter
	// ****************************************************************
	logic [15:0] psc_shadow_reg;  // Active prescaler value
	logic [15:0] arv_shadow_reg;  // Active auto-reload value
	logic [15:0] psc_cnt_reg;     // Prescaler divider count
	logic [15:0] cnt_reg;         // Main counter
	logic [31:0] rep_reg;         // Active repetition counter
	logic swu_prev_reg;           // Trigger edge detect
	logic swu_pulse;              // Software update request
	logic tick;                   // Counter tick clock
	logic overflow;               // Counter wrap
	logic upd_req;                // Update before inhibit
	logic upd;                    // Qualified update event
	logic [31:0] rep_load;        // Selected repetition reload

	assign swu_pulse = software_update_trigger & ~swu_prev_reg;
	// Direction bit must stay zero; a set bit stops the counter outright
	assign tick = counter_enable_bit && psc_in && !count_direction &&
		(psc_cnt_reg == psc_shadow_reg);
	assign overflow = tick && (cnt_reg >= arv_shadow_reg);
	assign upd_req = swu_pulse || (overflow && rep_reg == 32'h0000_0000);
	assign upd = upd_req && !update_inhibit;
	assign rep_load = repetition_counter_select ? repetition_count :
		{24'h00_0000, repetition_count[7:0]};

	// Prescaler divider; restarts on software update
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			psc_cnt_reg <= TCUT_PSC_RST;
		end else if (swu_pulse) begin
			psc_cnt_reg <= TCUT_PSC_RST;
		end else if (counter_enable_bit && psc_in) begin
			if (psc_cnt_reg == psc_shadow_reg) begin
				psc_cnt_reg <= TCUT_PSC_RST;
			end else begin
				psc_cnt_reg <= psc_cnt_reg + 16'h0001;
			end
		end
	end

	// Shadow loads only on a qualified update
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			psc_shadow_reg <= TCUT_PSC_RST;
			arv_shadow_reg <= TCUT_ARV_RST;
		end else if (upd) begin
			psc_shadow_reg <= prescaler_value;
			arv_shadow_reg <= auto_reload_value;
		end
	end

	// Main counter
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= TCUT_CNT_RST;
		end else if (swu_pulse) begin
			cnt_reg <= TCUT_CNT_RST;
		end else if (overflow) begin
			cnt_reg <= TCUT_CNT_RST;
		end else if (tick) begin
			cnt_reg <= cnt_reg + 16'h0001;
		end
	end

	// Repetition counter; reload on every update request, even inhibited
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rep_reg <= TCUT_REP_RST;
		end else if (swu_pulse || (upd_req && overflow)) begin
			rep_reg <= rep_load;
		end else if (overflow) begin
			rep_reg <= rep_reg - 32'h0000_0001;
		end
	end

	// Update strobe output and software trigger edge capture
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			update_event <= 1'b0;
			swu_prev_reg <= 1'b0;
		end else begin
			update_event <= upd;
			swu_prev_reg <= software_update_trigger;
		end
	end

	assign counter_value = cnt_reg;
	assign repetition_remaining = rep_reg;

	// ****************************************************************
	// Capture channels
	// ****************************************************************
	logic [2:0][3:0] flt_cnt_reg;  // Filter stability counters
	logic [2:0] flt_reg;           // Filtered levels
	logic [2:0] flt_prev_reg;      // Previous filtered levels
	logic [2:0][2:0] ipsc_reg;     // Input prescaler edge counters
	logic [2:0] edge_hit;          // Selected edge per channel
	logic [2:0] cap;               // Effective capture event

	// Digital filter: new level must hold for one sample more than the set number
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			flt_cnt_reg <= '0;
			flt_reg <= '0;
			flt_prev_reg <= '0;
		end else begin
			flt_prev_reg <= flt_reg;
			for (int c = 0; c < TCUT_NCH; c++) begin
				if (sync_reg[c] == flt_reg[c]) begin
					flt_cnt_reg[c] <= 4'h0;
				end else if (flt_cnt_reg[c] >= channel_cfg[c].filter_setting) begin
					flt_reg[c] <= sync_reg[c];
					flt_cnt_reg[c] <= 4'h0;
				end else begin
					flt_cnt_reg[c] <= flt_cnt_reg[c] + 4'h1;
				end
			end
		end
	end

	// Source pick and polarity; channels work independently
	always_comb begin
		for (int c = 0; c < TCUT_NCH; c++) begin
			logic now_l;
			logic was_l;
			now_l = flt_reg[c];
			was_l = flt_prev_reg[c];
			case (channel_cfg[c].source_select)
				TCUT_MS_NEXT: begin
					now_l = flt_reg[(c + 1) % TCUT_NCH];
					was_l = flt_prev_reg[(c + 1) % TCUT_NCH];
				end
				TCUT_MS_TRG: begin
					now_l = sync_reg[3 + c];
					was_l = sync_prev_reg[3 + c];
				end
				default: begin
					now_l = flt_reg[c];
					was_l = flt_prev_reg[c];
				end
			endcase
			edge_hit[c] = (channel_cfg[c].source_select != TCUT_MS_OUT) &&
				(multi_channel_mode_select == TCUT_MODE_INDEP) &&
				(channel_cfg[c].polarity ? (was_l && !now_l) :
				(now_l && !was_l));
		end
	end

	// Input prescaler: 1, 2, 4 or 8 edges per capture
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ipsc_reg <= '0;
		end else begin
			for (int c = 0; c < TCUT_NCH; c++) begin
				if (channel_cfg[c].source_select == TCUT_MS_OUT) begin
					ipsc_reg[c] <= 3'h0;
				end else if (cap[c]) begin
					ipsc_reg[c] <= 3'h0;
				end else if (edge_hit[c]) begin
					ipsc_reg[c] <= ipsc_reg[c] + 3'h1;
				end
			end
		end
	end

	always_comb begin
		for (int c = 0; c < TCUT_NCH; c++) begin
			cap[c] = edge_hit[c] && (ipsc_reg[c] ==
				3'((4'h1 << channel_cfg[c].input_prescale) - 4'h1));
		end
	end

	// Capture registers; writes allowed only in output mode
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			capture_value_register <= '0;
		end else begin
			for (int c = 0; c < TCUT_NCH; c++) begin
				if (cap[c]) begin
					capture_value_register[c] <= cnt_reg;
				end else if (cv_write[c] &&
					channel_cfg[c].source_select == TCUT_MS_OUT) begin
					capture_value_register[c] <= cv_wdata;
				end
			end
		end
	end

	// Flags: a capture wins over a clear in the same cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			channel_status <= '0;
		end else begin
			for (int c = 0; c < TCUT_NCH; c++) begin
				// Set terms come first, so a same-cycle clear loses
				channel_status[c].event_flag <= cap[c] ||
					(channel_status[c].event_flag && !flag_clear[c]);
				channel_status[c].overcapture_flag <=
					(cap[c] && channel_status[c].event_flag) ||
					(channel_status[c].overcapture_flag && !flag_clear[c]);
			end
		end
	end

	// Requests follow the sticky flag, gated by enables
	always_comb begin
		for (int c = 0; c < TCUT_NCH; c++) begin
			channel_irq[c] = channel_status[c].event_flag && channel_cfg[c].irq_enable;
			channel_dma_req[c] = channel_status[c].event_flag && channel_cfg[c].dma_enable;
		end
	end

endmodule : tcut_timer

// *** tcut_pkg.sv ***
// Package of constants and carrier types for the three channel up-count timer
package tcut_pkg;

	// ****************************************************************
	// Widths and counts
	// ****************************************************************
	localparam int TCUT_NCH = 3;                 // Channel count
	localparam int TCUT_CW = 16;                 // Counter width
	localparam int TCUT_FLTW = 4;                // Filter setting width

	// ****************************************************************
	// Clock source encodings
	// ****************************************************************
	localparam logic [4:0] TCUT_SRC_INT = 5'h00;      // Kernel clock
	localparam logic [4:0] TCUT_SRC_TRG_LO = 5'h01;   // First trigger input
	localparam logic [4:0] TCUT_SRC_TRG_HI = 5'h04;   // Last trigger input
	localparam logic [4:0] TCUT_SRC_PIN_LO = 5'h05;   // First pin edge mode
	localparam logic [4:0] TCUT_SRC_CH0_BOTH = 5'h05; // Channel 0 both edges
	localparam logic [4:0] TCUT_SRC_CH0_RISE = 5'h06; // Channel 0 rising edge
	localparam logic [4:0] TCUT_SRC_CH1_RISE = 5'h07; // Channel 1 rising edge

	// ****************************************************************
	// Channel input source encodings
	// ****************************************************************
	localparam logic [2:0] TCUT_MS_OUT = 3'h0;   // Output mode, no capture
	localparam logic [2:0] TCUT_MS_OWN = 3'h1;   // Own input
	localparam logic [2:0] TCUT_MS_NEXT = 3'h2;  // Neighbour channel input
	localparam logic [2:0] TCUT_MS_TRG = 3'h3;   // Internal trigger
	localparam logic [1:0] TCUT_MODE_INDEP = 2'h0; // Independent multi-channel mode

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [15:0] TCUT_CNT_RST = 16'h0000;
	localparam logic [15:0] TCUT_ARV_RST = 16'hFFFF;
	localparam logic [15:0] TCUT_PSC_RST = 16'h0000;
	localparam logic [31:0] TCUT_REP_RST = 32'h0000_0000;

	// Per-channel capture configuration
	typedef struct packed {
		logic [2:0] source_select;   // Channel input source select
		logic polarity;              // 1 = falling edge
		logic [3:0] filter_setting;  // Consecutive samples required, less one
		logic [1:0] input_prescale;  // Edges per capture: 1,2,4,8
		logic irq_enable;            // Channel interrupt enable
		logic dma_enable;            // Channel DMA enable
	} tcut_chcfg_t;

	// Per-channel status
	typedef struct packed {
		logic event_flag;            // Capture happened
		logic overcapture_flag;      // Capture while flag still set
	} tcut_chsts_t;

endpackage : tcut_pkg

// *** tcut_timer_props.sv ***
// Checker holding the port assertions of the three channel up-count timer
`timescale 1ns/100ps
module tcut_timer_props
	import tcut_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic counter_enable_bit,
	input wire logic software_update_trigger,
	input wire logic update_inhibit,
	input wire logic [1:0] multi_channel_mode_select,
	input wire tcut_chcfg_t [2:0] channel_cfg,
	input wire logic [2:0] cv_write,
	input wire logic [15:0] counter_value,
	input wire logic update_event,
	input wire logic [2:0][15:0] capture_value_register,
	input wire tcut_chsts_t [2:0] channel_status,
	input wire logic [2:0] channel_irq
);
	// ****************************************************************
	// Assertions, single kernel clock domain
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	// Counter only steps up by one or wraps back to zero
	a_count_up_step: assert property (
		$changed(counter_value) |-> (counter_value == $past(counter_value) + 16'h0001)
		|| (counter_value == 16'h0000)) else $error("counter jumped");
	// Disabled counter holds unless software clears it
	a_hold_disabled: assert property (
		!counter_enable_bit && !software_update_trigger |=> $stable(counter_value))
		else $error("counter moved while disabled");
	a_sw_update: assert property (
		$rose(software_update_trigger) && !update_inhibit |=> update_event
		&& counter_value == 16'h0000) else $error("software update missing");
	// Inhibit still lets the software trigger clear the counter
	a_sw_inhibited: assert property (
		$rose(software_update_trigger) && update_inhibit |=> !update_event
		&& counter_value == 16'h0000) else $error("inhibited software update");
	a_inhibit_quiet: assert property (
		update_inhibit |=> !update_event) else $error("update while inhibited");
	a_update_at_zero: assert property (
		update_event |-> counter_value == 16'h0000) else $error("update off zero");
	// Captured value is the count seen at the capture edge
	a_capture_value: assert property (
		$rose(channel_status[0].event_flag) |-> capture_value_register[0]
		== $past(counter_value)) else $error("capture value wrong");
	a_irq_follows: assert property (
		channel_irq[0] == (channel_status[0].event_flag & channel_cfg[0].irq_enable))
		else $error("irq not flag and enable");
	a_mode_blocks: assert property (
		multi_channel_mode_select != TCUT_MODE_INDEP
		|=> !$rose(channel_status[0].event_flag)) else $error("capture outside mode");
	// A capture may land on the same edge, so a set flag excuses a change
	a_cv_write_lock: assert property (
		cv_write[0] && channel_cfg[0].source_select != TCUT_MS_OUT
		|=> $stable(capture_value_register[0]) || channel_status[0].event_flag)
		else $error("input channel value written");
endmodule : tcut_timer_props

bind tcut_timer tcut_timer_props u_props (
	.clk(clk), .arst_n(arst_n), .counter_enable_bit(counter_enable_bit),
	.software_update_trigger(software_update_trigger), .update_inhibit(update_inhibit),
	.multi_channel_mode_select(multi_channel_mode_select), .channel_cfg(channel_cfg),
	.cv_write(cv_write), .counter_value(counter_value), .update_event(update_event),
	.capture_value_register(capture_value_register), .channel_status(channel_status),
	.channel_irq(channel_irq)
);

// *** tcut_far_model.sv ***
// Far-side model driving the capture pins and the internal trigger lines
`timescale 1ns/100ps
module tcut_far_model (
	output logic [2:0] channel_input_pin,
	output logic [3:0] internal_trigger_inputs,
	input wire logic clk
);
	// ****************************************************************
	// Line drivers
	// ****************************************************************
	// Lines idle low until an edge is asked for
	initial begin
		channel_input_pin = 3'h0;
		internal_trigger_inputs = 4'h0;
	end
	// Move one line, then hold it well past sync and filter depth
	task automatic drive(input logic pin_sel, input int idx, input logic lvl);
		@(posedge clk);
		if (pin_sel) begin
			channel_input_pin[idx] <= lvl;
		end else begin
			internal_trigger_inputs[idx] <= lvl;
		end
		repeat (12) @(posedge clk);
		#1;
	endtask : drive
endmodule : tcut_far_model

// *** tb_three_channel_upcount_timer.sv ***
// Self-checking testbench for the three channel up-count timer
`timescale 1ns/100ps
module tb_three_channel_upcount_timer
	import tcut_pkg::*;
;
	// ****************************************************************
	// Signals and instances
	// ****************************************************************
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [4:0] clock_source_select = 5'h00;
	logic counter_enable_bit = 1'b0;
	logic [15:0] prescaler_value = 16'h0000;
	logic [15:0] auto_reload_value = 16'h0000;
	logic [31:0] repetition_count = 32'h0000_0000;
	logic repetition_counter_select = 1'b0;
	logic software_update_trigger = 1'b0;
	logic update_inhibit = 1'b0;
	logic count_direction = 1'b0;
	logic [1:0] multi_channel_mode_select = 2'h0;
	logic [3:0] internal_trigger_inputs;
	logic [2:0] channel_input_pin;
	tcut_chcfg_t [2:0] channel_cfg = '0;
	logic [2:0] flag_clear = 3'h0;
	logic [2:0] cv_write = 3'h0;
	logic [15:0] cv_wdata = 16'h0000;
	logic [15:0] counter_value;
	logic [31:0] repetition_remaining;
	logic update_event;
	logic [2:0][15:0] capture_value_register;
	tcut_chsts_t [2:0] channel_status;
	logic [2:0] channel_irq;
	logic [2:0] channel_dma_req;
	int error_cnt = 0; // Mismatches seen
	int checks_done = 0; // Comparisons made
	int n;
	always #2.5 clk = ~clk;
	tcut_timer DUT (
		.clk(clk), .arst_n(arst_n), .clock_source_select(clock_source_select),
		.counter_enable_bit(counter_enable_bit), .prescaler_value(prescaler_value),
		.auto_reload_value(auto_reload_value), .repetition_count(repetition_count),
		.repetition_counter_select(repetition_counter_select),
		.software_update_trigger(software_update_trigger), .update_inhibit(update_inhibit),
		.count_direction(count_direction), .multi_channel_mode_select(multi_channel_mode_select),
		.internal_trigger_inputs(internal_trigger_inputs), .channel_input_pin(channel_input_pin),
		.channel_cfg(channel_cfg), .flag_clear(flag_clear), .cv_write(cv_write),
		.cv_wdata(cv_wdata), .counter_value(counter_value),
		.repetition_remaining(repetition_remaining), .update_event(update_event),
		.capture_value_register(capture_value_register), .channel_status(channel_status),
		.channel_irq(channel_irq), .channel_dma_req(channel_dma_req)
	);
	tcut_far_model far (
		.channel_input_pin(channel_input_pin),
		.internal_trigger_inputs(internal_trigger_inputs),
		.clk(clk)
	);
	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t got %0h expected %0h", $time, got, exp);
		end
	endtask : chk
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_sim
	// Software edge needs a low cycle before it, so pulse one cycle
	task automatic sw_upd;
		@(posedge clk);
		software_update_trigger <= 1'b1;
		@(posedge clk);
		software_update_trigger <= 1'b0;
		#1;
	endtask : sw_upd
	// Cycles until the next update pulse; a hang counts as a mismatch
	task automatic wait_upd(output int c);
		c = 0;
		do begin
			@(posedge clk);
			#1;
			c++;
		end while (update_event !== 1'b1 && c < 3000);
		if (c >= 3000) begin
			error_cnt++;
			end_sim();
		end
	endtask : wait_upd
	// Program the settings, then load them through a software update
	task automatic setup(input logic [15:0] p, input logic [15:0] a, input logic [31:0] r,
			input logic s);
		@(posedge clk);
		prescaler_value <= p;
		auto_reload_value <= a;
		repetition_count <= r;
		repetition_counter_select <= s;
		sw_upd();
	endtask : setup
	task automatic clr;
		@(posedge clk);
		flag_clear <= 3'h7;
		@(posedge clk);
		flag_clear <= 3'h0;
	endtask : clr
	// ****************************************************************
	// Test sequence
	// ****************************************************************
	initial begin
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		chk(counter_value, 0);
		chk(repetition_remaining, 0);
		@(posedge clk);
		counter_enable_bit <= 1'b1;
		setup(16'h0000, 16'h0002, 32'h0000_0000, 1'b0);
		chk(update_event, 1);
		chk(counter_value, 0);
		wait_upd(n);
		wait_upd(n);
		chk(n, 3);
		@(posedge clk);
		prescaler_value <= 16'h0003;
		// One cycle of the old three-cycle period is already spent here
		wait_upd(n);
		chk(n, 2);
		wait_upd(n);
		chk(n, 12);
		setup(16'h0000, 16'h0002, 32'h0000_0102, 1'b0);
		wait_upd(n);
		chk(repetition_remaining, 32'h0000_0002);
		wait_upd(n);
		chk(n, 9);
		setup(16'h0000, 16'h0002, 32'h0000_0102, 1'b1);
		wait_upd(n);
		chk(repetition_remaining, 32'h0000_0102);
		wait_upd(n);
		chk(n, 777);
		@(posedge clk);
		update_inhibit <= 1'b1;
		sw_upd();
		chk(update_event, 0);
		chk(counter_value, 0);
		n = 0;
		repeat (30) begin
			@(posedge clk);
			#1;
			if (update_event === 1'b1) n++;
		end
		chk(n, 0);
		// Drop the enable while counting; the count must freeze
		@(posedge clk);
		counter_enable_bit <= 1'b0;
		@(posedge clk);
		#1;
		n = counter_value;
		repeat (5) @(posedge clk);
		#1;
		chk(counter_value, n);
		@(posedge clk);
		update_inhibit <= 1'b0;
		counter_enable_bit <= 1'b1;
		$display("counting tests done");
		setup(16'h0000, 16'hFFFF, 32'h0000_0000, 1'b0);
		// Every external tick source, one edge count each
		for (int s = 1; s < 8; s++) begin
			@(posedge clk);
			clock_source_select <= 5'(s);
			sw_upd();
			repeat (4) begin
				far.drive(s > 4, (s < 5) ? s - 1 : s / 7, 1'b1);
				far.drive(s > 4, (s < 5) ? s - 1 : s / 7, 1'b0);
			end
			chk(counter_value, (s == 5) ? 8 : 4);
		end
		@(posedge clk);
		clock_source_select <= TCUT_SRC_INT;
		channel_cfg[0] <= {TCUT_MS_OUT, 1'b0, 4'h2, 2'h0, 1'b1, 1'b1};
		cv_write[0] <= 1'b1;
		cv_wdata <= 16'h1234;
		@(posedge clk);
		cv_write[0] <= 1'b0;
		channel_cfg[0] <= {TCUT_MS_OWN, 1'b0, 4'h2, 2'h0, 1'b1, 1'b1};
		@(posedge clk);
		cv_write[0] <= 1'b1;
		cv_wdata <= 16'h5678;
		@(posedge clk);
		cv_write[0] <= 1'b0;
		#1;
		chk(capture_value_register[0], 16'h1234);
		far.drive(1'b1, 0, 1'b1);
		chk(channel_status[0], 2'b10);
		chk(channel_irq, 3'h1);
		chk(channel_dma_req, 3'h1);
		far.drive(1'b1, 0, 1'b0);
		chk(channel_status[0], 2'b10);
		far.drive(1'b1, 0, 1'b1);
		chk(channel_status[0], 2'b11);
		clr();
		channel_cfg[1] <= {TCUT_MS_TRG, 1'b0, 4'h0, 2'h0, 1'b0, 1'b0};
		channel_cfg[2] <= {TCUT_MS_NEXT, 1'b1, 4'h2, 2'h0, 1'b0, 1'b0};
		far.drive(1'b1, 0, 1'b0);
		chk(channel_status, 6'h20);
		far.drive(1'b0, 1, 1'b1);
		chk(channel_status, 6'h28);
		far.drive(1'b0, 1, 1'b0);
		clr();
		channel_cfg[0].input_prescale <= 2'h1;
		far.drive(1'b1, 0, 1'b1);
		far.drive(1'b1, 0, 1'b0);
		far.drive(1'b1, 0, 1'b1);
		chk(channel_status[0], 2'b10);
		far.drive(1'b1, 0, 1'b0);
		clr();
		channel_cfg[0].input_prescale <= 2'h0;
		multi_channel_mode_select <= 2'h1;
		far.drive(1'b1, 0, 1'b1);
		chk(channel_status[0], 2'b00);
		$display("capture tests done");
		end_sim();
	end
endmodule : tb_three_channel_upcount_timer
